// ### hw/hcd_buf.sv
// endpoint buffer memory with one shared controller pointer
`timescale 1ns/1ps
module hcd_buf #(
    parameter int DEPTH = hcd_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic [2:0] sel,
    input wire logic sel_ld,
    input wire logic mcu_we,
    input wire logic mcu_adv,
    input wire logic [7:0] mcu_wdata,
    output logic [7:0] mcu_rdata,
    input wire logic usb_we,
    input wire logic [2:0] usb_ep,
    input wire logic [3:0] usb_idx,
    input wire logic [7:0] usb_wdata,
    output logic [7:0] usb_rdata
);
    localparam int PW = $clog2(DEPTH);
    localparam int NW = hcd_pkg::NEP * DEPTH;

    if (DEPTH < 2 || DEPTH > 16) begin : g_chk
        $error("hcd_buf: DEPTH must be 2..16");
    end

    logic [7:0] mem [NW];
    logic [PW-1:0] ptr_r;
    logic [PW-1:0] ptr_nxt;
    int unsigned ma;
    int unsigned ua;

    // pointer: cleared on select or reset, stepped on each byte until it holds at the last entry (DEPTH - 1)
    always_comb begin
        ptr_nxt = ptr_r;
        if (clr || sel_ld) begin
            ptr_nxt = '0; // R11
        end else if ((mcu_we || mcu_adv) && int'(ptr_r) < DEPTH - 1) begin
            ptr_nxt = ptr_r + 1'b1; // R17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // addresses into the flat memory
    always_comb begin
        ma = int'(sel) * DEPTH + int'(ptr_r);
        ua = int'(usb_ep) * DEPTH + int'(usb_idx);
        if (ua >= NW) begin
            ua = 0;
        end
        if (ma >= NW) begin
            ma = 0;
        end
    end

    // controller write has priority over any engine write in the same cycle
    always_ff @(posedge clk) begin
        if (mcu_we) begin
            mem[ma] <= mcu_wdata;
        end else if (usb_we) begin
            mem[ua] <= usb_wdata;
        end
    end

    assign mcu_rdata = mem[ma];
    assign usb_rdata = mem[ua];
endmodule

// ### hw/hcd_core.sv
// command decoder core: command/data byte decode, endpoint state, interrupt
`timescale 1ns/1ps
module hcd_core #(
    parameter int BUF_DEPTH = hcd_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input hcd_pkg::hcd_usb_s usb,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic int_n,
    output hcd_pkg::hcd_ctl_s ctl
);
    if (BUF_DEPTH < 2 || BUF_DEPTH > 16) begin : g_chk
        $error("hcd_core: BUF_DEPTH must be 2..16");
    end

    logic rs0_r;
    logic rst_n;
    logic [7:0] cmd_r, cmd_nxt;
    logic bidx_r, bidx_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [4:0] isrc_r, isrc_nxt;
    logic ipend_r, ipend_nxt;
    logic [4:0][4:0] last_r, last_nxt;
    hcd_pkg::hcd_ctl_s ctl_r, ctl_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rdv_r, rdv_nxt;
    logic int_n_r, int_n_nxt;
    logic [4:0] iclr;
    logic bwe, badv, bsel_ld;
    logic [7:0] brd, busr;
    logic [2:0] ep;
    logic [1:0] pt;
    logic a_sel, a_last, a_epst, a_pclr, a_pset;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs0_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs0_r <= 1'b1;
            rst_n <= rs0_r;
        end
    end

    // true for every defined command code
    function automatic logic known(input logic [7:0] c);
        logic g5;
        g5 = c[2:0] < 3'(hcd_pkg::NEP);
        known = ((c & hcd_pkg::GRP_MASK) == hcd_pkg::C_SEL && g5)
            || ((c & hcd_pkg::GRP_MASK) == hcd_pkg::C_LAST && g5)
            || ((c & hcd_pkg::GRP_MASK) == hcd_pkg::C_EPST && g5)
            || (c & hcd_pkg::PORT_MASK) == hcd_pkg::C_PCLR
            || (c & hcd_pkg::PORT_MASK) == hcd_pkg::C_PSET
            || c == hcd_pkg::C_HADDR || c == hcd_pkg::C_FADDR
            || c == hcd_pkg::C_EPEN || c == hcd_pkg::C_BUF
            || c == hcd_pkg::C_ACKS || c == hcd_pkg::C_CLRB
            || c == hcd_pkg::C_INT || c == hcd_pkg::C_FRM
            || c == hcd_pkg::C_RSM || c == hcd_pkg::C_STCH
            || c == hcd_pkg::C_VAL;
    endfunction

    // decode of the held command
    always_comb begin
        ep = cmd_r[2:0];
        pt = cmd_r[1:0];
        a_sel = (cmd_r & hcd_pkg::GRP_MASK) == hcd_pkg::C_SEL && ep < 3'(hcd_pkg::NEP);
        a_last = (cmd_r & hcd_pkg::GRP_MASK) == hcd_pkg::C_LAST && ep < 3'(hcd_pkg::NEP);
        a_epst = (cmd_r & hcd_pkg::GRP_MASK) == hcd_pkg::C_EPST && ep < 3'(hcd_pkg::NEP);
        a_pclr = (cmd_r & hcd_pkg::PORT_MASK) == hcd_pkg::C_PCLR;
        a_pset = (cmd_r & hcd_pkg::PORT_MASK) == hcd_pkg::C_PSET;
    end

    // next state of command, endpoint and interrupt logic
    always_comb begin
        cmd_nxt = cmd_r;
        bidx_nxt = bidx_r;
        sel_nxt = sel_r;
        isrc_nxt = isrc_r;
        ipend_nxt = ipend_r;
        last_nxt = last_r;
        ctl_nxt = ctl_r;
        ctl_nxt.port_set = '0;
        ctl_nxt.port_clr = '0;
        ctl_nxt.resume = 1'b0;
        ctl_nxt.usb_rdata = busr;
        rd_data_nxt = rd_data_r;
        rdv_nxt = 1'b0;
        iclr = '0;
        bwe = 1'b0;
        badv = 1'b0;
        bsel_ld = 1'b0;
        // engine send empties an IN buffer; a validate in the same cycle still wins
        for (int i = 0; i < hcd_pkg::NEP; i++) begin
            if (usb.tx_done[i] && !hcd_pkg::OUT_EPS[i]) begin
                ctl_nxt.buf_full[i] = 1'b0; // R19
            end
        end
        if (usb.hub_int_ack) begin
            ctl_nxt.hub_int_pend = 1'b0; // R10
        end
        if (cmd_valid) begin
            if (known(cmd_byte)) begin
                cmd_nxt = cmd_byte;
                bidx_nxt = 1'b0;
                if ((cmd_byte & hcd_pkg::GRP_MASK) == hcd_pkg::C_SEL) begin
                    sel_nxt = cmd_byte[2:0]; // R11
                    bsel_ld = 1'b1; // R11
                end
                if (cmd_byte == hcd_pkg::C_CLRB) begin
                    ctl_nxt.buf_full[sel_r] = 1'b0; // R18
                end
                if (cmd_byte == hcd_pkg::C_VAL) begin
                    ctl_nxt.buf_full[sel_r] = 1'b1; // R19
                end
                if (cmd_byte == hcd_pkg::C_RSM) begin
                    ctl_nxt.resume = 1'b1; // R16
                end
            end
            // unknown bytes touch nothing R21
        end else if (wr_valid) begin
            // write direction of shared codes R01
            if (cmd_r == hcd_pkg::C_HADDR) begin
                ctl_nxt.hub_addr = wr_byte; // R02
            end else if (cmd_r == hcd_pkg::C_FADDR) begin
                ctl_nxt.fn_addr = wr_byte; // R02
            end else if (cmd_r == hcd_pkg::C_EPEN) begin
                ctl_nxt.ep_en = wr_byte;
                ctl_nxt.ep_en[hcd_pkg::EPEN_HUB_INT] = wr_byte[hcd_pkg::EPEN_HUB_INT]
                    && ctl_r.hub_addr[hcd_pkg::EN_BIT]; // R04
                ctl_nxt.ep_en[hcd_pkg::EPEN_FN_INT] = wr_byte[hcd_pkg::EPEN_FN_INT]
                    && ctl_r.fn_addr[hcd_pkg::EN_BIT]; // R04
            end else if (cmd_r == hcd_pkg::C_BUF) begin
                bwe = 1'b1; // R17
            end else if (a_last) begin
                ctl_nxt.stall[ep] = wr_byte[0]; // R01
                if (!wr_byte[0]) begin
                    ctl_nxt.buf_full[ep] = 1'b0;
                end
            end else if (a_pclr) begin
                ctl_nxt.port_clr[pt] = 1'b1; // R14
                ctl_nxt.feat = wr_byte;
            end else if (a_pset) begin
                ctl_nxt.port_set[pt] = 1'b1; // R14
                ctl_nxt.feat = wr_byte;
            end else if (cmd_r == hcd_pkg::C_STCH) begin
                ctl_nxt.stat_chg = wr_byte; // R15
                ctl_nxt.hub_int_pend = |wr_byte; // R10
            end
        end else if (rd_req) begin
            // read direction of shared codes R01
            rdv_nxt = 1'b1;
            bidx_nxt = ~bidx_r;
            rd_data_nxt = hcd_pkg::RST_BYTE;
            if (cmd_r == hcd_pkg::C_INT) begin
                rd_data_nxt = {3'h0, isrc_r}; // R05
                ipend_nxt = 1'b0; // R08
            end else if (a_sel) begin
                rd_data_nxt = {7'h00, ctl_r.buf_full[ep]}; // R12
            end else if (a_last) begin
                rd_data_nxt = {3'h0, last_r[ep]}; // R13
                last_nxt[ep][4] = 1'b0; // R20
                iclr[ep] = 1'b1; // R20
            end else if (a_epst) begin
                rd_data_nxt = {6'h00, ctl_r.stall[ep], ctl_r.buf_full[ep]};
                iclr[ep] = 1'b1; // R06
            end else if (cmd_r == hcd_pkg::C_BUF) begin
                rd_data_nxt = brd;
                badv = 1'b1; // R17
            end else if (a_pclr) begin
                rd_data_nxt = bidx_r ? usb.port_stat[pt][15:8]
                    : usb.port_stat[pt][7:0]; // R14
            end else if (cmd_r == hcd_pkg::C_FRM) begin
                rd_data_nxt = bidx_r ? {5'h00, usb.frame[10:8]}
                    : usb.frame[7:0]; // R16
            end
        end
        // engine outcomes come after the controller's clears, so a new event wins
        for (int i = 0; i < hcd_pkg::NEP; i++) begin
            if (usb.xfer_done[i]) begin
                last_nxt[i] = {1'b1, usb.xfer_code}; // R13
                if (hcd_pkg::OUT_EPS[i]) begin
                    ctl_nxt.buf_full[i] = 1'b1; // R18
                end
            end
        end
        // a new outcome wins over a clear in the same cycle
        isrc_nxt = (isrc_r & ~iclr) | usb.xfer_done;
        if (usb.bus_rst) begin
            // same as hardware reset except rd_data is held, plus a raised interrupt R09
            cmd_nxt = hcd_pkg::RST_BYTE;
            bidx_nxt = 1'b0;
            sel_nxt = '0;
            last_nxt = '0;
            ctl_nxt = '0;
            ctl_nxt.hub_addr = hcd_pkg::RST_ADDR; // R03
            ctl_nxt.fn_addr = hcd_pkg::RST_ADDR;
            isrc_nxt = '0; // R07
            ipend_nxt = 1'b1; // R07
        end
        int_n_nxt = !(ipend_nxt || |isrc_nxt);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= hcd_pkg::RST_BYTE;
            bidx_r <= 1'b0;
            sel_r <= '0;
            isrc_r <= '0;
            ipend_r <= 1'b0;
            last_r <= '0;
            ctl_r <= '0;
            rd_data_r <= hcd_pkg::RST_BYTE;
            rdv_r <= 1'b0;
            int_n_r <= 1'b1;
        end else begin
            cmd_r <= cmd_nxt;
            bidx_r <= bidx_nxt;
            sel_r <= sel_nxt;
            isrc_r <= isrc_nxt;
            ipend_r <= ipend_nxt;
            last_r <= last_nxt;
            ctl_r <= ctl_nxt;
            rd_data_r <= rd_data_nxt;
            rdv_r <= rdv_nxt;
            int_n_r <= int_n_nxt;
        end
    end

    // endpoint buffers
    hcd_buf #(
        .DEPTH(BUF_DEPTH)
    ) hcd_buf_inst (
        .clk(clk),
        .rst_n(rst_n),
        .clr(usb.bus_rst),
        .sel(sel_r),
        .sel_ld(bsel_ld),
        .mcu_we(bwe),
        .mcu_adv(badv),
        .mcu_wdata(wr_byte),
        .mcu_rdata(brd),
        .usb_we(usb.buf_we),
        .usb_ep(usb.buf_ep),
        .usb_idx(usb.buf_idx),
        .usb_wdata(usb.buf_wdata),
        .usb_rdata(busr)
    );

    assign rd_valid = rdv_r;
    assign rd_data = rd_data_r;
    assign int_n = int_n_r;
    assign ctl = ctl_r;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_INT_RD: assert property ( // R05
        rd_req && !cmd_valid && !wr_valid && cmd_r == hcd_pkg::C_INT
        |=> rd_valid && rd_data == {3'h0, $past(isrc_r)})
        else $error("interrupt source read wrong");
    AST_BUSRST_INT: assert property (usb.bus_rst |=> !int_n && isrc_r == '0) // R07
        else $error("bus reset did not raise interrupt");
    AST_BUSRST_DIS: assert property ( // R09
        usb.bus_rst |=> !ctl.hub_addr[hcd_pkg::EN_BIT] && ctl.ep_en == '0)
        else $error("bus reset left hub enabled");
    AST_EPST_CLR: assert property ( // R06
        rd_req && !cmd_valid && !wr_valid && a_epst
        && usb.xfer_done == '0 |=> isrc_r[$past(ep)] == 1'b0)
        else $error("endpoint status read kept source bit");
    AST_SEL_RD: assert property ( // R12
        rd_req && !cmd_valid && !wr_valid && a_sel
        |=> rd_data == {7'h00, $past(ctl.buf_full[ep])})
        else $error("select read wrong");
    AST_INTEP_GATE: assert property ( // R04
        wr_valid && !cmd_valid && cmd_r == hcd_pkg::C_EPEN
        && !ctl.hub_addr[hcd_pkg::EN_BIT] && !usb.bus_rst
        |=> !ctl.ep_en[hcd_pkg::EPEN_HUB_INT])
        else $error("interrupt endpoint enabled while hub disabled");
    AST_FULL_RX: assert property (usb.xfer_done[0] && !usb.bus_rst |=> ctl.buf_full[0]) // R18
        else $error("received packet did not fill buffer");
    AST_RSM: assert property ( // R16
        cmd_valid && cmd_byte == hcd_pkg::C_RSM && !usb.bus_rst
        |=> ctl.resume ##1 (!ctl.resume || $past(cmd_valid && cmd_byte == hcd_pkg::C_RSM)))
        else $error("resume not one pulse");
    AST_INT_CLR: assert property ( // R08
        rd_req && !cmd_valid && !wr_valid && cmd_r == hcd_pkg::C_INT
        && isrc_r == '0 && usb.xfer_done == '0 && !usb.bus_rst |=> int_n)
        else $error("interrupt not released after read");
    AST_LAST_NEW: assert property (usb.xfer_done[2] && !usb.bus_rst |=> last_r[2][4]) // R13
        else $error("new outcome not marked unread");
    AST_TX_EMPTY: assert property ( // R19
        usb.tx_done[1] && !cmd_valid && !usb.bus_rst |=> !ctl.buf_full[1])
        else $error("sent packet left buffer full");

    // main scenarios: bus reset, buffer and port reads, engine send, stall write
    COV_BUSRST: cover property (usb.bus_rst ##1 !int_n);
    COV_BUF_RD: cover property (rd_req && cmd_r == hcd_pkg::C_BUF ##1 rd_req);
    COV_PORT_RD: cover property (rd_req && a_pclr ##1 rd_req && a_pclr);
    COV_TX: cover property (usb.tx_done[1] ##1 !ctl.buf_full[1]);
    COV_STALL_WR: cover property (wr_valid && a_last ##1 ctl.stall[0]);
endmodule

// ### pkg/hcd_pkg.sv
// constants, carriers and command codes of the hub command decoder
// What this block does
// [R01] shared codes pick read or write operation from data direction
// [R02] D0h/D1h write byte sets hub or function address and enable
// [R03] hub leaves reset disabled; controller re-enables after every bus reset
// [R04] D8h enables endpoints; interrupt endpoints only if owner already enabled
// [R05] F4h read returns interrupt source byte, one bit per endpoint
// [R06] 80h-84h read one status byte and clear that endpoint's source bit
// [R07] after bus reset interrupt asserted while source byte reads zero
// [R08] reading the interrupt source byte clears internal interrupt indication
// [R09] bus reset acts exactly as hardware reset but also raises interrupt; the code leaves the read data byte (rd_data) unchanged
// [R10] hub interrupt endpoint served by hardware without controller action
// [R11] 00h-04h select endpoint and reset buffer pointer to its start
// [R12] read after select returns 0 for empty, 1 for full buffer
// [R13] 40h-44h read returns last transaction outcome of that endpoint
// [R14] E0h-E3h write clears, E8h-EBh write sets port feature, E0h-E3h read status
// [R15] F7h write byte updates hub status change bits
// [R16] F5h reads frame number in one or two bytes; F6h starts resume
// [R17] every buffer byte read or written advances the pointer by one; the code holds it at the last entry (DEPTH - 1)
// [R18] received packet sets buffer full; F2h frees the buffer
// [R19] F2h counterpart FAh marks filled IN buffer full for next IN
// [R20] last status read also clears interrupt flag and marks status read
// [R21] unknown command bytes are accepted and otherwise ignored
package hcd_pkg;
    localparam int NEP = 5;
    localparam int NPORT = 4;
    localparam int BUF_DEPTH = 10;
    localparam logic [7:0] GRP_MASK = 8'hF8;
    localparam logic [7:0] PORT_MASK = 8'hFC;
    localparam logic [7:0] C_SEL = 8'h00;
    localparam logic [7:0] C_LAST = 8'h40;
    localparam logic [7:0] C_EPST = 8'h80;
    localparam logic [7:0] C_HADDR = 8'hD0;
    localparam logic [7:0] C_FADDR = 8'hD1;
    localparam logic [7:0] C_EPEN = 8'hD8;
    localparam logic [7:0] C_PCLR = 8'hE0;
    localparam logic [7:0] C_PSET = 8'hE8;
    localparam logic [7:0] C_BUF = 8'hF0;
    localparam logic [7:0] C_ACKS = 8'hF1;
    localparam logic [7:0] C_CLRB = 8'hF2;
    localparam logic [7:0] C_INT = 8'hF4;
    localparam logic [7:0] C_FRM = 8'hF5;
    localparam logic [7:0] C_RSM = 8'hF6;
    localparam logic [7:0] C_STCH = 8'hF7;
    localparam logic [7:0] C_VAL = 8'hFA;
    localparam int EN_BIT = 7;
    localparam int EPEN_HUB_INT = 0;
    localparam int EPEN_FN_INT = 1;
    localparam logic [4:0] OUT_EPS = 5'h05;
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // events and data from the serial engine side
    typedef struct packed {
        logic bus_rst;
        logic [NEP-1:0] xfer_done;
        logic [3:0] xfer_code;
        logic [NEP-1:0] tx_done;
        logic [10:0] frame;
        logic [NPORT-1:0][15:0] port_stat;
        logic hub_int_ack;
        logic buf_we;
        logic [2:0] buf_ep;
        logic [3:0] buf_idx;
        logic [7:0] buf_wdata;
    } hcd_usb_s;

    // registered controls toward the serial engine and ports
    typedef struct packed {
        logic [7:0] hub_addr;
        logic [7:0] fn_addr;
        logic [7:0] ep_en;
        logic [7:0] stat_chg;
        logic [7:0] feat;
        logic [NPORT-1:0] port_set;
        logic [NPORT-1:0] port_clr;
        logic [NEP-1:0] buf_full;
        logic [NEP-1:0] stall;
        logic resume;
        logic hub_int_pend;
        logic [7:0] usb_rdata;
    } hcd_ctl_s;
endpackage

// ### verif/hcd_core_tb.sv
// self-checking testbench of the hub command decoder core
`timescale 1ns/1ps
module hcd_core_tb;
    logic clk;
    logic arst_n;
    logic cmd_valid, wr_valid, rd_req, rd_valid, int_n;
    logic [7:0] cmd_byte, wr_byte, rd_data, rb;
    hcd_pkg::hcd_usb_s usb;
    hcd_pkg::hcd_ctl_s ctl;
    int n_fail;
    int cmp_count;

    // free-running clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    hcd_core hcd_core_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
        .usb(usb), .rd_valid(rd_valid), .rd_data(rd_data), .int_n(int_n), .ctl(ctl));

    hcd_mcu_model hcd_mcu_model_inst (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .rd_req(rd_req));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] b);
        hcd_mcu_model_inst.send_cmd(b);
    endtask

    task automatic wr(input logic [7:0] b);
        hcd_mcu_model_inst.send_wr(b);
    endtask

    // read one byte and compare; a missing answer ends the run
    task automatic rd_chk(input logic [7:0] exp, input string what);
        bit ok;
        hcd_mcu_model_inst.read_byte(rb, ok);
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: no read answer", $time);
            tally_and_finish();
        end
        chk({8'h00, rb}, {8'h00, exp}, what);
    endtask

    // engine-side one-cycle event: 0 transaction done, 1 bus reset, 2 hub int ack, 3 sent
    task automatic usb_pulse(input int kind, input int ep, input logic [3:0] code);
        @(posedge clk);
        usb.xfer_code <= code;
        if (kind == 0) usb.xfer_done[ep] <= 1'b1;
        if (kind == 1) usb.bus_rst <= 1'b1;
        if (kind == 2) usb.hub_int_ack <= 1'b1;
        if (kind == 3) usb.tx_done[ep] <= 1'b1;
        @(posedge clk);
        usb.xfer_done <= '0;
        usb.tx_done <= '0;
        usb.bus_rst <= 1'b0;
        usb.hub_int_ack <= 1'b0;
        #1;
    endtask

    // bounded wait for the interrupt line to reach a level
    task automatic wait_int(input logic lvl);
        int i;
        for (i = 0; i < 8 && int_n !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
        if (int_n !== lvl) begin
            n_fail++;
            $display("unexpected at %0t: interrupt line stuck", $time);
            tally_and_finish();
        end
    endtask

    task automatic t_init;
        chk(ctl.hub_addr, 8'h00, "hub disabled out of reset");
        chk(int_n, 1'b1, "no interrupt out of reset");
        cmd(hcd_pkg::C_EPEN);
        wr(8'h03);
        chk(ctl.ep_en[1:0], 2'b00, "int eps need enabled owner");
        cmd(hcd_pkg::C_HADDR);
        wr(8'h85);
        chk(ctl.hub_addr, 8'h85, "hub address");
        cmd(hcd_pkg::C_FADDR);
        wr(8'h83);
        chk(ctl.fn_addr, 8'h83, "function address");
        cmd(hcd_pkg::C_EPEN);
        wr(8'h03);
        chk(ctl.ep_en[1:0], 2'b11, "int eps enabled");
    endtask

    task automatic t_buffer;
        cmd(8'h01);
        rd_chk(8'h00, "select reports empty");
        cmd(hcd_pkg::C_BUF);
        wr(8'h00);
        wr(8'h02);
        wr(8'hA5);
        wr(8'h5A);
        cmd(hcd_pkg::C_VAL);
        chk(ctl.buf_full[1], 1'b1, "validate marks full");
        cmd(8'h01);
        rd_chk(8'h01, "select reports full");
        cmd(hcd_pkg::C_BUF);
        rd_chk(8'h00, "buffer byte 0");
        rd_chk(8'h02, "buffer byte 1");
        rd_chk(8'hA5, "buffer byte 2");
        rd_chk(8'h5A, "buffer byte 3");
        @(posedge clk);
        usb.buf_ep <= 3'd1;
        usb.buf_idx <= 4'd2;
        repeat (3) @(posedge clk);
        #1;
        chk(ctl.usb_rdata, 8'hA5, "engine side read");
        usb_pulse(3, 1, 4'h0);
        chk(ctl.buf_full[1], 1'b0, "sent IN packet empties buffer");
        cmd(hcd_pkg::C_VAL);
        cmd(hcd_pkg::C_CLRB);
        chk(ctl.buf_full[1], 1'b0, "clear frees buffer");
    endtask

    task automatic t_status;
        usb_pulse(0, 2, 4'h5);
        wait_int(1'b0);
        chk(int_n, 1'b0, "transaction raises interrupt");
        chk(ctl.buf_full[2], 1'b1, "received packet fills buffer");
        cmd(hcd_pkg::C_INT);
        rd_chk(8'h04, "source bit of ep 2");
        cmd(8'h42);
        rd_chk(8'h15, "last status unread");
        cmd(8'h42);
        rd_chk(8'h05, "last status now read");
        cmd(hcd_pkg::C_INT);
        rd_chk(8'h00, "last status read clears source");
        usb_pulse(0, 3, 4'h0);
        cmd(8'h83);
        rd_chk(8'h00, "ep 3 status");
        cmd(hcd_pkg::C_INT);
        rd_chk(8'h00, "status read clears source");
        cmd(8'h40);
        wr(8'h01);
        chk(ctl.stall[0], 1'b1, "40h write sets stall");
        cmd(8'h80);
        cmd(8'h20);
        rd_chk(8'h02, "unknown code keeps prior command");
        cmd(8'h40);
        rd_chk(8'h00, "40h read leaves stall");
        chk(ctl.stall[0], 1'b1, "stall kept");
    endtask

    task automatic t_hub;
        cmd(8'hE1);
        wr(8'h08);
        chk(ctl.port_clr, 4'h2, "clear feature port 3");
        chk(ctl.feat, 8'h08, "feature byte");
        cmd(8'hE9);
        wr(8'h10);
        chk(ctl.port_set, 4'h2, "set feature port 3");
        cmd(8'hE2);
        rd_chk(8'hEF, "port 4 status low");
        rd_chk(8'hBE, "port 4 status high");
        cmd(hcd_pkg::C_FRM);
        rd_chk(8'hA3, "frame low");
        rd_chk(8'h05, "frame high");
        cmd(hcd_pkg::C_RSM);
        chk(ctl.resume, 1'b1, "resume pulse");
        cmd(hcd_pkg::C_STCH);
        wr(8'h3C);
        chk(ctl.stat_chg, 8'h3C, "status change bits");
        chk(ctl.hub_int_pend, 1'b1, "hub int pending");
        usb_pulse(2, 0, 4'h0);
        chk(ctl.hub_int_pend, 1'b0, "engine serves hub int");
    endtask

    task automatic t_bus_reset;
        usb_pulse(1, 0, 4'h0);
        wait_int(1'b0);
        chk(int_n, 1'b0, "bus reset raises interrupt");
        chk(ctl.hub_addr, 8'h00, "bus reset disables hub");
        chk(ctl.stall[0], 1'b0, "bus reset clears stall");
        cmd(hcd_pkg::C_INT);
        rd_chk(8'h00, "empty sources after bus reset");
        wait_int(1'b1);
        chk(int_n, 1'b1, "source read clears interrupt");
    endtask

    // reset, then each scenario in turn
    initial begin
        n_fail = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        usb = '0;
        usb.frame = 11'h5A3;
        usb.port_stat[2] = 16'hBEEF;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_init();
        t_buffer();
        t_status();
        t_hub();
        t_bus_reset();
        tally_and_finish();
    end
endmodule

// ### verif/hcd_mcu_model.sv
// controller-side model: issues command, data write and data read requests
`timescale 1ns/1ps
module hcd_mcu_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    output logic rd_req
);
    // idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        wr_valid = 1'b0;
        wr_byte = 8'h00;
        rd_req = 1'b0;
    end

    // one byte to the command address; released byte lines show the inverse
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_byte <= ~b;
        #1;
    endtask

    // one byte written to the data address (write direction)
    task automatic send_wr(input logic [7:0] b);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_byte <= b;
        @(posedge clk);
        wr_valid <= 1'b0;
        wr_byte <= ~b;
        #1;
    endtask

    // one byte read from the data address, answer awaited under a bound
    task automatic read_byte(output logic [7:0] d, output bit ok);
        int i;
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        for (i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end else begin
                @(posedge clk);
            end
        end
    endtask
endmodule
